// ### verification/dfcam_ctrl_monitor.sv
/* checker for the fast column access controller: strobe order, spacing and address timing at the pins.
   assumes it is bound to the controller and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// pin checker
module dfcam_ctrl_monitor
    import dfcam_pkg::*;
#(
    parameter int unsigned ROW_W = 10,
    parameter int unsigned COL_W = 10
) (
    // clock and reset
    input wire logic             CLK_IN,
    input wire logic             RST_N_IN,
    // requests
    input wire logic [1:0]       MODE_IN,
    input wire logic             REQ_VALID_IN,
    input wire logic             REQ_READY_OUT,
    input wire logic             REQ_WRITE_IN,
    input wire logic [ROW_W-1:0] REQ_ROW_IN,
    input wire logic [COL_W-1:0] REQ_COL_IN,
    // dram pins
    input wire logic             RAS_N_OUT,
    input wire logic             CAS_N_OUT,
    input wire logic             WE_N_OUT,
    input wire logic [ROW_W-1:0] ADDR_OUT,
    input wire logic             DQ_OE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    logic [5:0]       hi_cnt;
    logic [5:0]       rc_cnt;
    logic [1:0]       rmode;
    logic             last_wr;
    logic [ROW_W-1:0] last_row;
    logic [ROW_W-1:0] last_col;
    // counters saturate so a long idle never wraps into a false short gap
    wire              take    = REQ_VALID_IN && REQ_READY_OUT;
    wire  [5:0]       next_hi = RAS_N_OUT ? hi_cnt + 6'(hi_cnt != 6'h3F) : 6'h00;
    wire  [5:0]       next_rc = rc_cnt + 6'(rc_cnt != 6'h3F);
    // track precharge length, row cycle, open-row mode and the last request taken
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            hi_cnt <= 6'h3F;
            rc_cnt <= 6'h3F;
            rmode <= MODE_RANDOM;
            last_wr <= 1'b0;
            last_row <= '0;
            last_col <= '0;
        end else begin
            hi_cnt <= next_hi;
            rc_cnt <= $fell(RAS_N_OUT) ? 6'h00 : next_rc;
            rmode <= $fell(RAS_N_OUT) ? MODE_IN : rmode;
            last_wr <= take ? REQ_WRITE_IN : last_wr;
            last_row <= take ? REQ_ROW_IN : last_row;
            last_col <= take ? ROW_W'(REQ_COL_IN) : last_col;
        end
    end
    // ==========================================
    // assertions
    property p_cas_in_row;
        $fell(CAS_N_OUT) |-> !RAS_N_OUT && !$past(RAS_N_OUT);
    endproperty
    a_cas_in_row: assert property (p_cas_in_row) else $error("column strobe fell outside open row");
    property p_page_gap;
        $fell(CAS_N_OUT) && rmode == MODE_PAGE |=> (!$fell(CAS_N_OUT)) [*6];
    endproperty
    a_page_gap: assert property (p_page_gap) else $error("page accesses too close");
    property p_nib_gap;
        $fell(CAS_N_OUT) && rmode == MODE_NIBBLE |=> (!$fell(CAS_N_OUT)) [*4];
    endproperty
    a_nib_gap: assert property (p_nib_gap) else $error("nibble accesses too close");
    property p_static_hold;
        $rose(CAS_N_OUT) && rmode == MODE_STATIC |-> $rose(RAS_N_OUT);
    endproperty
    a_static_hold: assert property (p_static_hold) else $error("select toggled inside static row");
    property p_precharge;
        $fell(RAS_N_OUT) |-> hi_cnt >= 6'h0A;
    endproperty
    a_precharge: assert property (p_precharge) else $error("row reopened before precharge");
    property p_rand_cycle;
        $fell(RAS_N_OUT) |-> rc_cnt >= 6'h14;
    endproperty
    a_rand_cycle: assert property (p_rand_cycle) else $error("row cycle shorter than minimum");
    property p_row_addr;
        $fell(RAS_N_OUT) |-> ADDR_OUT == last_row;
    endproperty
    a_row_addr: assert property (p_row_addr) else $error("wrong row on row strobe");
    property p_col_addr;
        $fell(CAS_N_OUT) && rmode inside {MODE_RANDOM, MODE_PAGE} |-> ADDR_OUT == last_col;
    endproperty
    a_col_addr: assert property (p_col_addr) else $error("wrong column on column strobe");
    property p_we_match;
        $fell(CAS_N_OUT) |-> WE_N_OUT == !last_wr;
    endproperty
    a_we_match: assert property (p_we_match) else $error("write strobe disagrees with request");
    property p_oe_we;
        DQ_OE_OUT != WE_N_OUT && (!DQ_OE_OUT || (!CAS_N_OUT && !RAS_N_OUT));
    endproperty
    a_oe_we: assert property (p_oe_we) else $error("data driven outside a write access");
endmodule
bind dfcam_ctrl dfcam_ctrl_monitor #(.ROW_W(ROW_W), .COL_W(COL_W)) u_monitor (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .MODE_IN(MODE_IN), .REQ_VALID_IN(REQ_VALID_IN),
    .REQ_READY_OUT(REQ_READY_OUT), .REQ_WRITE_IN(REQ_WRITE_IN), .REQ_ROW_IN(REQ_ROW_IN),
    .REQ_COL_IN(REQ_COL_IN), .RAS_N_OUT(RAS_N_OUT), .CAS_N_OUT(CAS_N_OUT), .WE_N_OUT(WE_N_OUT),
    .ADDR_OUT(ADDR_OUT), .DQ_OE_OUT(DQ_OE_OUT)
);
`default_nettype wire

// ### verification/dfcam_ctrl_tb_top.sv
/* bench for the fast column access controller: scenario tasks issue requests, a device model answers.
   assumes the monitor is bound to the controller. */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench top
module dfcam_ctrl_tb_top;
    import dfcam_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] mode = MODE_RANDOM;
    logic       req_valid = 1'b0;
    logic       req_write = 1'b0;
    logic       req_last = 1'b0;
    logic [9:0] req_row = 10'h000;
    logic [9:0] req_col = 10'h000;
    logic       req_data = 1'b0;
    logic       rd_ready = 1'b1;
    wire        req_ready, rd_valid, rd_data, ras_n, cas_n, we_n, dq, dq_oe, dq_ret;
    wire  [9:0] addr;
    int         err_count = 0;
    int         compares = 0;
    logic       q [$];
    // free-running clock
    always #4 clk = ~clk;
    dfcam_ctrl dut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .MODE_IN(mode), .REQ_VALID_IN(req_valid), .REQ_READY_OUT(req_ready),
        .REQ_WRITE_IN(req_write), .REQ_LAST_IN(req_last), .REQ_ROW_IN(req_row), .REQ_COL_IN(req_col),
        .REQ_DATA_IN(req_data), .RD_VALID_OUT(rd_valid), .RD_READY_IN(rd_ready), .RD_DATA_OUT(rd_data),
        .RAS_N_OUT(ras_n), .CAS_N_OUT(cas_n), .WE_N_OUT(we_n), .ADDR_OUT(addr), .DQ_OUT(dq),
        .DQ_OE_OUT(dq_oe), .DQ_IN(dq_ret)
    );
    dfcam_dram_model u_dram (
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .addr_in(addr), .dq_in(dq), .dq_out(dq_ret),
        .mode_in(mode)
    );
    // read words taken at the falling edge, where buffer outputs have settled
    always @(negedge clk) begin
        if (rd_valid === 1'b1 && rd_ready) q.push_back(rd_data);
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one request, held until taken; valid stays up so back-to-back requests need no gap
    task automatic acc(input logic wr, input logic last, input logic [9:0] row, input logic [9:0] col, input logic d);
        int k;
        req_valid = 1'b1;
        req_write = wr;
        req_last = last;
        req_row = row;
        req_col = col;
        req_data = d;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 300);
        if (k >= 300) begin
            err_count++;
            end_sim();
        end
        @(posedge clk);
        #1;
    endtask
    task automatic run(input logic [1:0] m, input logic [9:0] row, input int n, input logic [7:0] wr,
                       input logic [7:0] dat, input logic [9:0] cols [8]);
        mode = m;
        for (int i = 0; i < n; i++) acc(wr[i], i == n - 1, row, cols[i], dat[i]);
        req_valid = 1'b0;
    endtask
    // wait, bounded, for n read words and compare them in order
    task automatic want(input int n, input logic [31:0] e);
        int k;
        k = 0;
        while (q.size() < n && k < 400) begin
            @(posedge clk);
            k++;
        end
        check("words", q.size(), n);
        if (q.size() < n) end_sim();
        for (int i = 0; i < n; i++) check("rd_data", q.pop_front(), e[i]);
        @(posedge clk);
        #1;
    endtask
    task automatic s_random;
        run(MODE_RANDOM, 10'h005, 4, 8'h03, 8'h01, '{10'h003, 10'h004, 10'h003, 10'h004, 0, 0, 0, 0});
        want(2, 32'h0000_0001);
    endtask
    task automatic s_page;
        run(MODE_PAGE, 10'h009, 6, 8'h0B, 8'h09, '{10'h3FF, 10'h000, 10'h3FF, 10'h007, 10'h000, 10'h007, 0, 0});
        want(3, 32'h0000_0005);
    endtask
    task automatic s_nibble;
        run(MODE_PAGE, 10'h014, 4, 8'h0F, 8'h09, '{10'h004, 10'h005, 10'h006, 10'h007, 0, 0, 0, 0});
        run(MODE_NIBBLE, 10'h014, 6, 8'h00, 8'h00, '{10'h006, 10'h100, 10'h200, 10'h300, 10'h3FF, 10'h001, 0, 0});
        want(6, 32'h0000_0026);
    endtask
    task automatic s_static;
        run(MODE_STATIC, 10'h021, 6, 8'h07, 8'h05, '{10'h002, 10'h384, 10'h003, 10'h384, 10'h002, 10'h003, 0, 0});
        want(3, 32'h0000_0006);
    endtask
    // fill the read buffer with the far side stalled, see reads refused, then drain it
    task automatic s_fifo;
        int n;
        n = 0;
        rd_ready = 1'b0;
        mode = MODE_PAGE;
        for (int i = 0; i < 16; i++) acc(1'b0, 1'b0, 10'h014, 10'(4 + i % 4), 1'b0);
        req_col = 10'h004;
        repeat (40) begin
            @(negedge clk);
            n += int'(req_ready === 1'b1);
        end
        check("ready_full", n, 0);
        check("rd_valid", rd_valid, 1);
        @(posedge clk);
        #1;
        rd_ready = 1'b1;
        acc(1'b0, 1'b1, 10'h014, 10'h004, 1'b0);
        req_valid = 1'b0;
        want(17, 32'h0001_9999);
        check("rd_empty", rd_valid, 0);
    endtask
    // reset for 12 cycles with strobes idle, then the scenarios
    initial begin
        repeat (12) @(posedge clk);
        check("ras_idle", ras_n, 1);
        check("cas_idle", cas_n, 1);
        check("oe_idle", dq_oe, 0);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        s_random();
        s_page();
        s_nibble();
        s_static();
        s_fifo();
        end_sim();
    end
endmodule
`default_nettype wire

// ### verification/dfcam_dram_model.sv
/* behavioural one-bit-wide dram with page, nibble and static column access.
   assumes strobes from the controller; data is polled every ns at half-ns offsets. */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// device model
module dfcam_dram_model
    import dfcam_pkg::*;
(
    // controller pins
    input  wire logic       ras_n_in,
    input  wire logic       cas_n_in,
    input  wire logic       we_n_in,
    input  wire logic [9:0] addr_in,
    input  wire logic       dq_in,
    output logic            dq_out,
    // part flavour; a one-bit-wide part, so nibble is offered
    input  wire logic [1:0] mode_in
);
    bit         mem [0:1048575];
    logic [9:0] row;
    logic [9:0] col;
    realtime    t0;
    realtime    lat;
    bit         first;
    logic [1:0] pmode;
    // row opens on the falling strobe; every row keeps its data after it closes, no decay modelled
    always @(negedge ras_n_in) begin
        t0 = $realtime;
        lat = ROW_ACCESS_LATENCY_NS;
        // the access flavour is fixed for the whole open row, whatever the bench does meanwhile
        pmode = mode_in;
        first = 1'b1;
        #0.1 row = addr_in;
    end
    // column strobe: page takes a fresh column, nibble steps its own two-bit counter
    always @(negedge cas_n_in) begin
        #0.1;
        if (!ras_n_in && pmode == MODE_NIBBLE && !first) begin
            col[1:0] = col[1:0] + 2'h1;
        end else if (!ras_n_in) begin
            col = addr_in;
        end
        if (!first) begin
            t0 = $realtime;
            lat = (pmode == MODE_NIBBLE) ? NIBBLE_ACCESS_LATENCY_NS : COLUMN_STROBE_ACCESS_LATENCY_NS;
        end
        first = 1'b0;
    end
    // static column: an address change with both strobes low starts a new access
    always @(addr_in) begin
        if (pmode == MODE_STATIC && !ras_n_in && !cas_n_in && !first) begin
            col = addr_in;
            t0 = $realtime;
            lat = ADDRESS_ACCESS_LATENCY_NS;
        end
    end
    // poll off the clock edges; data not yet valid flips every poll so early sampling fails
    initial begin
        dq_out = 1'b0;
        #0.5;
        forever begin
            if (!ras_n_in && !cas_n_in && !we_n_in) mem[{row, col}] = dq_in;
            if (!ras_n_in && !cas_n_in && we_n_in && $realtime - t0 >= lat) dq_out = mem[{row, col}];
            else dq_out = ~dq_out;
            #1;
        end
    end
endmodule
`default_nettype wire

// ### verilog/dfcam_ctrl.sv
/*
 * host side controller for fast column access of an asynchronous dram:
 * random, page, nibble and static column bursts, plus the read data fifo.
 * assumes pin inputs synchronous to CLK_IN and one request in flight.
 */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// read data fifo
module dfcam_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // filling side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr, rd_ptr;
    logic [PW:0]      count;
    // handshakes and occupancy
    wire push = in_valid_in && in_ready_out;
    wire pop  = out_valid_out && out_ready_in;
    assign in_ready_out  = (count != FULL_CNT);
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];
    // pointers wrap explicitly so any depth works, not just powers of two
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
    // storage has no reset; out_valid_out guards stale words
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule
// ==========================================================
// strobe sequencer
module dfcam_ctrl
    import dfcam_pkg::*;
#(
    parameter int unsigned ROW_W   = 10,
    parameter int unsigned COL_W   = 10,
    parameter int unsigned DATA_W  = 1,
    parameter int unsigned FIFO_D  = 16
) (
    // clock and reset
    input  wire logic              CLK_IN,
    input  wire logic              RST_N_IN,
    // configuration
    input  wire logic [1:0]        MODE_IN,
    // access requests
    input  wire logic              REQ_VALID_IN,
    output logic                   REQ_READY_OUT,
    input  wire logic              REQ_WRITE_IN,
    input  wire logic              REQ_LAST_IN,
    input  wire logic [ROW_W-1:0]  REQ_ROW_IN,
    input  wire logic [COL_W-1:0]  REQ_COL_IN,
    input  wire logic [DATA_W-1:0] REQ_DATA_IN,
    // read data
    output logic                   RD_VALID_OUT,
    input  wire logic              RD_READY_IN,
    output logic [DATA_W-1:0]      RD_DATA_OUT,
    // dram pins
    output logic                   RAS_N_OUT,
    output logic                   CAS_N_OUT,
    output logic                   WE_N_OUT,
    output logic [ROW_W-1:0]       ADDR_OUT,
    output logic [DATA_W-1:0]      DQ_OUT,
    output logic                   DQ_OE_OUT,
    input  wire logic [DATA_W-1:0] DQ_IN
);
    localparam int unsigned AW = (ROW_W > COL_W) ? ROW_W : COL_W;
    // access latency after the first one of a row
    function automatic logic [CNT_W-1:0] lat_of(input dfcam_mode_e m);
        return (m == MODE_NIBBLE) ? NCAC_CYC : (m == MODE_STATIC) ? AA_CYC : CAC_CYC;
    endfunction
    // least spacing of fast accesses: strobe fall to strobe fall, address change to address change in static
    function automatic logic [CNT_W-1:0] cmin_of(input dfcam_mode_e m);
        return (m == MODE_NIBBLE) ? NC_CYC : (m == MODE_STATIC) ? SC_CYC : PC_CYC;
    endfunction
    logic              rst_meta, rst_n;
    dfcam_state_e      state, next_state;
    dfcam_mode_e       cur_mode;
    logic [ROW_W-1:0]  open_row;
    logic [COL_W-1:0]  cur_col;
    logic [DATA_W-1:0] cur_data;
    logic              cur_write, cur_last, first, taken;
    logic [CNT_W-1:0]  acc_cnt, rc_cnt, rp_cnt;
    logic              fifo_in_ready;
    // ==========================================================
    // reset release through two flops
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end
    // ==========================================================
    // decode
    // nibble needs the one-bit organisation; wider parts fall back to page
    wire dfcam_mode_e req_mode = (DATA_W > 1 && MODE_IN == MODE_NIBBLE) ? MODE_PAGE
                                 : dfcam_mode_e'(MODE_IN);
    // nibble ignores the column, so only the row must match
    wire row_hit    = (cur_mode != MODE_RANDOM) && (REQ_ROW_IN == open_row);
    wire lat_met    = first ? (rc_cnt >= RAC_CYC) : (acc_cnt >= lat_of(cur_mode));
    wire strobe_mode = (cur_mode != MODE_STATIC);
    wire cyc_met    = acc_cnt >= (strobe_mode ? cmin_of(cur_mode) - CNT_ONE
                                              : cmin_of(cur_mode));
    wire acc_end    = (state == ST_ACC) && taken;
    wire can_cont   = acc_end && cyc_met && !cur_last && row_hit;
    wire close_now  = acc_end && (cur_last || cur_mode == MODE_RANDOM
                                  || (REQ_VALID_IN && !row_hit));
    wire idle_ok    = (state == ST_IDLE) && (rp_cnt == CNT_ZERO) && (rc_cnt >= RC_CYC);
    wire push       = (state == ST_ACC) && lat_met && !taken && !cur_write;
    // a read is only taken while its fifo slot is already free
    // held low while the internal reset copy is still asserted, so nothing is offered and then dropped
    assign REQ_READY_OUT = rst_n && (idle_ok || can_cont) && (REQ_WRITE_IN || fifo_in_ready);
    wire accept     = REQ_VALID_IN && REQ_READY_OUT;
    // ==========================================================
    // state sequence
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_ROW;
                end
            end
            ST_ROW:  next_state = ST_ACC;
            ST_ACC: begin
                if (accept && strobe_mode) begin
                    next_state = ST_GAP;
                end else if (accept) begin
                    next_state = ST_ACC;
                end else if (close_now) begin
                    next_state = ST_IDLE;
                end
            end
            ST_GAP:  next_state = ST_ACC;
            default: next_state = ST_IDLE;
        endcase
    end
    wire next_row_low = (next_state != ST_IDLE);
    wire next_col_low = (next_state == ST_ACC);
    wire [COL_W-1:0] next_col = accept ? REQ_COL_IN : cur_col;
    wire [AW-1:0] next_addr = (next_state == ST_ROW) ? AW'(REQ_ROW_IN) : AW'(next_col);
    wire next_we = next_col_low && (accept ? REQ_WRITE_IN : cur_write);
    // ==========================================================
    // state and request registers
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            cur_mode  <= MODE_RANDOM;
            open_row  <= '0;
            cur_col   <= '0;
            cur_data  <= '0;
            cur_write <= 1'b0;
            cur_last  <= 1'b0;
        end else begin
            state <= next_state;
            if (accept) begin
                cur_col   <= REQ_COL_IN;
                cur_data  <= REQ_DATA_IN;
                cur_write <= REQ_WRITE_IN;
                cur_last  <= REQ_LAST_IN;
            end
            if (accept && state == ST_IDLE) begin
                open_row <= REQ_ROW_IN;
                cur_mode <= req_mode;
            end
        end
    end
    // ==========================================================
    // access progress: the device runs nibble and column order itself
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            first <= 1'b0;
            taken <= 1'b0;
        end else begin
            if (state == ST_ROW) begin
                first <= 1'b1;
            end else if (accept) begin
                first <= 1'b0;
            end
            if (next_state == ST_ACC && state != ST_ACC || accept) begin
                taken <= 1'b0;
            end else if (state == ST_ACC && lat_met) begin
                taken <= 1'b1;
            end
        end
    end
    // ==========================================================
    // timers: access/cycle, row cycle, precharge
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            acc_cnt <= CNT_ZERO;
            rc_cnt  <= RC_CYC;
            rp_cnt  <= CNT_ZERO;
        end else begin
            acc_cnt <= (next_col_low && (state != ST_ACC || accept)) ? CNT_ZERO : acc_cnt + CNT_ONE;
            if (next_state == ST_ROW) begin
                rc_cnt <= CNT_ZERO;
            end else if (rc_cnt < RC_CYC) begin
                rc_cnt <= rc_cnt + CNT_ONE;
            end
            if (close_now && !accept) begin
                rp_cnt <= RP_CYC;
            end else if (rp_cnt != CNT_ZERO) begin
                rp_cnt <= rp_cnt - CNT_ONE;
            end
        end
    end
    // ==========================================================
    // pins come from flops so the dram sees clean edges
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            RAS_N_OUT <= 1'b1;
            CAS_N_OUT <= 1'b1;
            WE_N_OUT  <= 1'b1;
            DQ_OE_OUT <= 1'b0;
            ADDR_OUT  <= '0;
            DQ_OUT    <= '0;
        end else begin
            RAS_N_OUT <= !next_row_low;
            CAS_N_OUT <= !next_col_low;
            WE_N_OUT  <= !next_we;
            DQ_OE_OUT <= next_we;
            ADDR_OUT  <= ROW_W'(next_addr);
            DQ_OUT    <= accept ? REQ_DATA_IN : cur_data;
        end
    end
    // ==========================================================
    // read data queue; a stalled reader stops new reads
    dfcam_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk_in        (CLK_IN),
        .rst_n_in      (rst_n),
        .in_valid_in   (push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (DQ_IN),
        .out_valid_out (RD_VALID_OUT),
        .out_ready_in  (RD_READY_IN),
        .out_data_out  (RD_DATA_OUT)
    );
endmodule

`default_nettype wire

// ### verilog/dfcam_pkg.sv
/*
 * constants, timing figures and enumerations for the fast column access
 * controller of an asynchronous dram.
 * assumes a single 125 mhz system clock; device timing figures are nanoseconds, the clock period picoseconds.
 */
package dfcam_pkg;

    // ==========================================================
    // clock and counter sizing
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned CNT_W         = 6;

    // least times round up to whole cycles
    function automatic int unsigned ceil_cyc(input int unsigned ns);
        return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction

    // ==========================================================
    // device timing figures in nanoseconds
    localparam int unsigned ROW_ACCESS_LATENCY_NS           = 85;
    localparam int unsigned COLUMN_STROBE_ACCESS_LATENCY_NS = 25;
    localparam int unsigned NIBBLE_ACCESS_LATENCY_NS        = 20;
    localparam int unsigned ADDRESS_ACCESS_LATENCY_NS       = 45;
    localparam int unsigned PAGE_CYCLE_MIN_NS               = 50;
    localparam int unsigned NIBBLE_CYCLE_MIN_NS             = 40;
    localparam int unsigned STATIC_CYCLE_MIN_NS             = 50;
    localparam int unsigned RANDOM_CYCLE_MIN_NS             = 165;
    localparam int unsigned ROW_PRECHARGE_MIN_NS            = 80;

    // ==========================================================
    // the same figures as clock counts
    localparam logic [CNT_W-1:0] RAC_CYC  = CNT_W'(ceil_cyc(ROW_ACCESS_LATENCY_NS));
    localparam logic [CNT_W-1:0] CAC_CYC  = CNT_W'(ceil_cyc(COLUMN_STROBE_ACCESS_LATENCY_NS));
    localparam logic [CNT_W-1:0] NCAC_CYC = CNT_W'(ceil_cyc(NIBBLE_ACCESS_LATENCY_NS));
    localparam logic [CNT_W-1:0] AA_CYC   = CNT_W'(ceil_cyc(ADDRESS_ACCESS_LATENCY_NS));
    localparam logic [CNT_W-1:0] PC_CYC   = CNT_W'(ceil_cyc(PAGE_CYCLE_MIN_NS));
    localparam logic [CNT_W-1:0] NC_CYC   = CNT_W'(ceil_cyc(NIBBLE_CYCLE_MIN_NS));
    localparam logic [CNT_W-1:0] SC_CYC   = CNT_W'(ceil_cyc(STATIC_CYCLE_MIN_NS));
    localparam logic [CNT_W-1:0] RC_CYC   = CNT_W'(ceil_cyc(RANDOM_CYCLE_MIN_NS));
    localparam logic [CNT_W-1:0] RP_CYC   = CNT_W'(ceil_cyc(ROW_PRECHARGE_MIN_NS));
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // ==========================================================
    // access modes and controller states
    typedef enum logic [1:0] {
        MODE_RANDOM = 2'h0,
        MODE_PAGE   = 2'h1,
        MODE_NIBBLE = 2'h2,
        MODE_STATIC = 2'h3
    } dfcam_mode_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ROW  = 4'h2,
        ST_ACC  = 4'h4,
        ST_GAP  = 4'h8
    } dfcam_state_e;

endpackage
